// File: design/cnpc_map.vh
// register map, key codes and bus constants of the nonvolatile program control
`ifndef CNPC_MAP_VH
`define CNPC_MAP_VH
`define CNPC_TARGET_ADDR 7'h10
`define CNPC_LOC_TRIM 4'h0
`define CNPC_LOC_FIRST 4'h1
`define CNPC_LOC_LAST 4'hA
`define CNPC_LOC_KEY 4'hB
`define CNPC_KEY_PROGRAM 8'h41
`define CNPC_KEY_PREREAD 8'h62
`define CNPC_KEY_RESET 8'h00
`define CNPC_CFG_BYTES 10
`define CNPC_CFG_W 80
`define CNPC_NVM_W 88
`define CNPC_NVM_RESET 88'h0
`define CNPC_SYNC_RESET 4'h3
`define CNPC_BIT_SCL 0
`define CNPC_BIT_SDA 1
`define CNPC_BIT_EN 2
`define CNPC_BIT_STB 3
`define CNPC_LAST_BIT 4'h7
`define CNPC_BYTE_END 4'h8
`endif

// File: design/cnpc_nvm_ctrl.v
// configuration store with serial register access, key-gated commit and parity fail-safe
`timescale 1ns/1ps
`default_nettype none
`include "cnpc_map.vh"
module cnpc_nvm_ctrl
(
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // serial port pins
  input wire serial_port_enable_pin,
  input wire serial_clock_line,
  input wire serial_data_line_i,
  output reg serial_data_line_o_q,
  output reg serial_data_line_oe_q,
  // program strobe pin
  input wire nvm_write_strobe_pin,
  // fet requests from protection logic, same clock
  input wire discharge_fet_request,
  input wire charge_fet_request,
  // fet drives and status
  output reg discharge_fet_drive_q,
  output reg charge_fet_drive_q,
  output reg parity_error_q,
  // active configuration
  output reg [`CNPC_CFG_W-1:0] cfg_q
);
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_REG = 3'd2;
  localparam [2:0] ST_WDAT = 3'd3;
  localparam [2:0] ST_RDAT = 3'd4;
  localparam [2:0] ST_ACK = 3'd5;
  localparam [2:0] ST_MACK = 3'd6;

  function [7:0] colpar;
    input [`CNPC_NVM_W-1:0] v;
    integer i;
    begin
      colpar = 8'h00;
      for (i = 0; i < `CNPC_NVM_W / 8; i = i + 1)
        colpar = colpar ^ v[i*8 +: 8];
    end
  endfunction

  reg [3:0] s1_q, s2_q, s3_q, f_q, fp_q;
  reg [`CNPC_NVM_W-1:0] nvm_q;
  reg [7:0] par_q;
  reg [7:0] key_q;
  reg load_q;
  reg [2:0] st_q, nxt_q;
  reg [3:0] cnt_q;
  reg [7:0] shr_q;
  reg [3:0] ptr_q;
  reg done_q;
  reg [7:0] rd_byte;
  reg [`CNPC_NVM_W-1:0] cfg_ext;
  // one loop index per process so no variable has two drivers
  integer k;
  integer j;
  integer m;

  // pins pass three flops; a level counts once stages two and three agree
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= `CNPC_SYNC_RESET;
      s2_q <= `CNPC_SYNC_RESET;
      s3_q <= `CNPC_SYNC_RESET;
      f_q <= `CNPC_SYNC_RESET;
      fp_q <= `CNPC_SYNC_RESET;
    end
    else
    begin
      s1_q <= {nvm_write_strobe_pin, serial_port_enable_pin, serial_data_line_i, serial_clock_line};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (k = 0; k < 4; k = k + 1)
        if (s2_q[k] == s3_q[k])
          f_q[k] <= s3_q[k];
      fp_q <= f_q;
    end
  end

  wire scl_rise = f_q[`CNPC_BIT_SCL] & ~fp_q[`CNPC_BIT_SCL];
  wire scl_fall = ~f_q[`CNPC_BIT_SCL] & fp_q[`CNPC_BIT_SCL];
  wire sda = f_q[`CNPC_BIT_SDA];
  wire start_cond = f_q[`CNPC_BIT_SCL] & fp_q[`CNPC_BIT_SCL] & ~sda & fp_q[`CNPC_BIT_SDA];
  wire stop_cond = f_q[`CNPC_BIT_SCL] & fp_q[`CNPC_BIT_SCL] & sda & ~fp_q[`CNPC_BIT_SDA];
  wire port_en = f_q[`CNPC_BIT_EN];
  wire strobe_fall = ~f_q[`CNPC_BIT_STB] & fp_q[`CNPC_BIT_STB];
  wire key_prog = (key_q == `CNPC_KEY_PROGRAM);
  wire key_pre = (key_q == `CNPC_KEY_PREREAD);

  // config laid out at stored-location positions so one index serves both
  always @*
  begin
    cfg_ext = {cfg_q, nvm_q[7:0]};
    rd_byte = 8'h00;
    j = 0;
    if (ptr_q == `CNPC_LOC_KEY)
      rd_byte = key_q;
    else if (ptr_q == `CNPC_LOC_TRIM)
      rd_byte = nvm_q[7:0];
    else if (ptr_q <= `CNPC_LOC_LAST)
    begin
      for (j = 1; j <= `CNPC_CFG_BYTES; j = j + 1)
        if (ptr_q == j[3:0])
          rd_byte = key_pre ? nvm_q[j*8 +: 8] : cfg_ext[j*8 +: 8];
    end
  end

  // stored array: no real reset in silicon, modelled as a blank part
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nvm_q <= `CNPC_NVM_RESET;
      par_q <= 8'h00;
    end
    else if (strobe_fall && key_prog && load_q)
    begin
      nvm_q[`CNPC_NVM_W-1:8] <= cfg_q;
      par_q <= colpar({cfg_q, nvm_q[7:0]});
    end
  end

  // parity is rechecked every cycle so a disturbed cell trips at once
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      parity_error_q <= 1'b0;
      discharge_fet_drive_q <= 1'b0;
      charge_fet_drive_q <= 1'b0;
    end
    else
    begin
      parity_error_q <= (colpar(nvm_q) != par_q);
      discharge_fet_drive_q <= discharge_fet_request & load_q & (colpar(nvm_q) == par_q);
      charge_fet_drive_q <= charge_fet_request & load_q & (colpar(nvm_q) == par_q);
    end
  end

  // serial target with register pointer and auto-increment
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_q <= {`CNPC_CFG_W{1'b0}};
      key_q <= `CNPC_KEY_RESET;
      load_q <= 1'b0;
      st_q <= ST_IDLE;
      nxt_q <= ST_IDLE;
      cnt_q <= 4'h0;
      shr_q <= 8'h00;
      ptr_q <= 4'h0;
      done_q <= 1'b0;
      serial_data_line_o_q <= 1'b0;
      serial_data_line_oe_q <= 1'b0;
    end
    else if (!load_q)
    begin
      cfg_q <= nvm_q[`CNPC_NVM_W-1:8];
      load_q <= 1'b1;
    end
    else if (!port_en)
    begin
      st_q <= ST_IDLE;
      serial_data_line_oe_q <= 1'b0;
    end
    else if (start_cond)
    begin
      st_q <= ST_ADDR;
      cnt_q <= 4'h0;
      done_q <= 1'b0;
      serial_data_line_oe_q <= 1'b0;
    end
    else if (stop_cond)
    begin
      st_q <= ST_IDLE;
      serial_data_line_oe_q <= 1'b0;
    end
    else if (scl_rise)
    begin
      case (st_q)
        ST_ADDR, ST_REG, ST_WDAT:
        begin
          shr_q <= {shr_q[6:0], sda};
          cnt_q <= cnt_q + 4'h1;
          done_q <= (cnt_q == `CNPC_LAST_BIT);
        end
        ST_RDAT: cnt_q <= cnt_q + 4'h1;
        ST_MACK: done_q <= sda;
        default: cnt_q <= cnt_q;
      endcase
    end
    else if (scl_fall)
    begin
      case (st_q)
        ST_ADDR:
          if (done_q)
          begin
            if (shr_q[7:1] == `CNPC_TARGET_ADDR)
            begin
              serial_data_line_oe_q <= 1'b1;
              nxt_q <= shr_q[0] ? ST_RDAT : ST_REG;
              st_q <= ST_ACK;
            end
            else
              st_q <= ST_IDLE;
          end
        ST_REG:
          if (done_q)
          begin
            ptr_q <= shr_q[3:0];
            serial_data_line_oe_q <= 1'b1;
            nxt_q <= ST_WDAT;
            st_q <= ST_ACK;
          end
        ST_WDAT:
          if (done_q)
          begin
            if (ptr_q == `CNPC_LOC_KEY)
              key_q <= shr_q;
            for (m = 1; m <= `CNPC_CFG_BYTES; m = m + 1)
              if (ptr_q == m[3:0])
                cfg_q[(m-1)*8 +: 8] <= shr_q;
            ptr_q <= ptr_q + 4'h1;
            serial_data_line_oe_q <= 1'b1;
            nxt_q <= ST_WDAT;
            st_q <= ST_ACK;
          end
        ST_ACK:
        begin
          cnt_q <= 4'h0;
          done_q <= 1'b0;
          st_q <= nxt_q;
          if (nxt_q == ST_RDAT)
          begin
            serial_data_line_oe_q <= ~rd_byte[7];
            shr_q <= {rd_byte[6:0], 1'b0};
            ptr_q <= ptr_q + 4'h1;
          end
          else
            serial_data_line_oe_q <= 1'b0;
        end
        ST_RDAT:
          if (cnt_q == `CNPC_BYTE_END)
          begin
            serial_data_line_oe_q <= 1'b0;
            st_q <= ST_MACK;
          end
          else
          begin
            serial_data_line_oe_q <= ~shr_q[7];
            shr_q <= {shr_q[6:0], 1'b0};
          end
        ST_MACK:
          if (done_q)
            st_q <= ST_IDLE;
          else
          begin
            cnt_q <= 4'h0;
            serial_data_line_oe_q <= ~rd_byte[7];
            shr_q <= {rd_byte[6:0], 1'b0};
            ptr_q <= ptr_q + 4'h1;
            st_q <= ST_RDAT;
          end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: sim/cnpc_nvm_ctrl_assertions.sv
// port checker of the nonvolatile program control
`timescale 1ns/1ps
`default_nettype none
`include "cnpc_map.vh"
module cnpc_chk
(
  // clock, reset, inputs
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic serial_port_enable_pin,
  input wire logic discharge_fet_request,
  input wire logic charge_fet_request,
  // outputs
  input wire logic serial_data_line_o_q,
  input wire logic serial_data_line_oe_q,
  input wire logic discharge_fet_drive_q,
  input wire logic charge_fet_drive_q,
  input wire logic parity_error_q,
  input wire logic [`CNPC_CFG_W-1:0] cfg_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_o_low; !serial_data_line_o_q; endproperty
  a_o_low: assert property (p_o_low) else $error("data out high");
  property p_oe_idle; !serial_port_enable_pin [*6] |-> !serial_data_line_oe_q; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("drives while disabled");
  property p_cfg_hold; !serial_port_enable_pin [*8] |=> $stable(cfg_q); endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved while disabled");
  // drives and the error flag come from one parity compare at the same edge
  property p_par_off; parity_error_q |-> (!discharge_fet_drive_q && !charge_fet_drive_q); endproperty
  a_par_off: assert property (p_par_off) else $error("fet on with parity error");
  property p_dis_off; !discharge_fet_request |=> !discharge_fet_drive_q; endproperty
  a_dis_off: assert property (p_dis_off) else $error("discharge on unasked");
  property p_chg_off; !charge_fet_request |=> !charge_fet_drive_q; endproperty
  a_chg_off: assert property (p_chg_off) else $error("charge on unasked");
  property p_dis_on; discharge_fet_request [*2] |=> (discharge_fet_drive_q || parity_error_q); endproperty
  a_dis_on: assert property (p_dis_on) else $error("discharge not on");
  property p_chg_on; charge_fet_request [*2] |=> (charge_fet_drive_q || parity_error_q); endproperty
  a_chg_on: assert property (p_chg_on) else $error("charge not on");
  c_ack: cover property (serial_data_line_oe_q);
  c_cfg: cover property (!$stable(cfg_q));
  c_dis: cover property ($rose(discharge_fet_drive_q));
  c_par: cover property ($rose(parity_error_q));
endmodule
bind cnpc_nvm_ctrl cnpc_chk chk_u (.mclk(mclk), .rst_n(rst_n), .serial_port_enable_pin(serial_port_enable_pin),
  .discharge_fet_request(discharge_fet_request), .charge_fet_request(charge_fet_request),
  .serial_data_line_o_q(serial_data_line_o_q), .serial_data_line_oe_q(serial_data_line_oe_q),
  .discharge_fet_drive_q(discharge_fet_drive_q), .charge_fet_drive_q(charge_fet_drive_q),
  .parity_error_q(parity_error_q), .cfg_q(cfg_q));
`default_nettype wire

// File: sim/cnpc_host.sv
// host model: serial master, enable strap and commit strobe
`timescale 1ns/1ps
`default_nettype none
module cnpc_host
(
  // clock and wire level
  input wire logic mclk,
  input wire logic sda,
  // host pins
  output logic en,
  output logic scl,
  output logic sda_low,
  output logic stb
);
  initial
  begin
    en = 1'b1;
    scl = 1'b1;
    sda_low = 1'b0;
    stb = 1'b0;
  end
  // within a byte, data moves only while the clock is low, so no false start or stop
  task ph(input logic c, input logic d);
    repeat (8) @(posedge mclk);
    scl <= c;
    sda_low <= ~d;
  endtask
  task start;
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    ph(1'b0, 1'b0);
  endtask
  task stop;
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  task xb(input logic [8:0] w, output logic [8:0] r);
    integer i;
    for (i = 8; i >= 0; i = i - 1)
    begin
      ph(1'b0, w[i]);
      ph(1'b1, w[i]);
      repeat (4) @(posedge mclk);
      r[i] = sda;
      ph(1'b0, w[i]);
    end
  endtask
  task commit;
    repeat (8) @(posedge mclk);
    stb <= 1'b1;
    repeat (8) @(posedge mclk);
    stb <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: sim/cnpc_nvm_ctrl_bench.sv
// self-checking bench of the nonvolatile program control
`timescale 1ns/1ps
`default_nettype none
`include "cnpc_map.vh"
module cnpc_nvm_ctrl_bench;
  logic mclk, rst_n, dreq, creq;
  logic [8:0] r;
  integer n_mismatch = 0, total_checks = 0, cyc = 0;
  wire sda, oe, o, dfet, cfet, perr, scl, en, sdl, stb;
  wire [`CNPC_CFG_W-1:0] cfg;
  // open drain wire with pull-up
  assign sda = ~(oe | sdl);
  cnpc_host host_u (.mclk(mclk), .sda(sda), .en(en), .scl(scl), .sda_low(sdl), .stb(stb));
  cnpc_nvm_ctrl dut_u (.mclk(mclk), .rst_n(rst_n), .serial_port_enable_pin(en), .serial_clock_line(scl),
    .serial_data_line_i(sda), .serial_data_line_o_q(o), .serial_data_line_oe_q(oe),
    .nvm_write_strobe_pin(stb), .discharge_fet_request(dreq), .charge_fet_request(creq),
    .discharge_fet_drive_q(dfet), .charge_fet_drive_q(cfet), .parity_error_q(perr), .cfg_q(cfg));
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task chk(input logic [79:0] seen, input logic [79:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 60000)
    begin
      n_mismatch = n_mismatch + 1;
      wrap_up;
    end
  end
  task head(input logic [3:0] p, input logic ack);
    host_u.start;
    host_u.xb({`CNPC_TARGET_ADDR, 2'b01}, r);
    chk(r[0], ack);
    host_u.xb({4'h0, p, 1'b1}, r);
  endtask
  task wr(input logic [3:0] p, input logic [7:0] d);
    head(p, 1'b0);
    host_u.xb({d, 1'b1}, r);
    host_u.stop;
  endtask
  task rd(input logic [3:0] p, input logic [7:0] e);
    head(p, 1'b0);
    host_u.start;
    host_u.xb({`CNPC_TARGET_ADDR, 2'b11}, r);
    host_u.xb(9'h1FF, r);
    chk(r[8:1], e);
    host_u.stop;
  endtask
  initial
  begin
    rst_n = 1'b0;
    dreq = 1'b0;
    creq = 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    chk(cfg, 80'h0);
    chk({o, oe, perr}, 3'b000);
    rd(4'hB, 8'h00);
    host_u.start;
    host_u.xb({7'h30, 2'b01}, r);
    chk(r[0], 1'b1);
    host_u.stop;
    wr(4'h1, 8'hA5);
    wr(4'hA, 8'h3C);
    chk({cfg[79:72], cfg[7:0]}, 16'h3CA5);
    wr(4'hB, 8'h40);
    host_u.commit;
    wr(4'hB, `CNPC_KEY_PREREAD);
    host_u.commit;
    rd(4'hB, 8'h62);
    rd(4'h1, 8'h00);
    wr(4'hB, `CNPC_KEY_PROGRAM);
    host_u.commit;
    wr(4'h1, 8'h5A);
    wr(4'hB, `CNPC_KEY_PREREAD);
    rd(4'h1, 8'hA5);
    rd(4'hA, 8'h3C);
    wr(4'hB, 8'h00);
    rd(4'h1, 8'h5A);
    host_u.en <= 1'b0;
    head(4'h1, 1'b1);
    host_u.xb({8'hC3, 1'b1}, r);
    host_u.stop;
    host_u.en <= 1'b1;
    rd(4'h1, 8'h5A);
    dreq <= 1'b1;
    creq <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({dfet, cfet, perr}, 3'b110);
    creq <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({dfet, cfet}, 2'b10);
    // flip one stored cell to stand for a disturbed bit
    dut_u.nvm_q[8] = ~dut_u.nvm_q[8];
    creq <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({dfet, cfet, perr}, 3'b001);
    wrap_up;
  end
endmodule
`default_nettype wire
